// File: rtl/ecrec_pkg.sv
// Purpose: constants for the exception cause recorder
// Assumes: 32-bit register port, bit 0 is the most significant bit of a word
// Notes: offsets of the register port are local choices

package ecrec_pkg;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  localparam int ECREC_ADDR_W = 4;
  localparam logic [3:0] ECREC_OFF_CAUSE = 4'h0;
  localparam logic [3:0] ECREC_OFF_MASK = 4'h4;
  localparam logic [3:0] ECREC_OFF_DBGCTL = 4'h8;
  localparam logic [31:0] ECREC_CAUSE_RESET = 32'h0000_0000;
  localparam logic [31:0] ECREC_MASK_RESET = 32'h0000_0000;
  localparam logic [2:0] ECREC_DBGCTL_RESET = 3'h0;

  // ----------------------------------------
  // cause bit positions, numbered from the msb
  // ----------------------------------------
  localparam int ECREC_B_RESET = 1;
  localparam int ECREC_B_CHECKSTOP = 2;
  localparam int ECREC_B_MCHECK = 3;
  localparam int ECREC_B_OUTSIDE = 6;
  localparam int ECREC_B_ALIGN = 7;
  localparam int ECREC_B_PROGRAM = 8;
  localparam int ECREC_B_FPUNAVAIL = 9;
  localparam int ECREC_B_DECR = 10;
  localparam int ECREC_B_SYSCALL = 13;
  localparam int ECREC_B_TRACE = 14;
  localparam int ECREC_B_FPASSIST = 15;
  localparam int ECREC_B_EMUL = 17;
  localparam int ECREC_B_IPROT = 19;
  localparam int ECREC_B_DPROT = 21;

  // implemented bits, msb-numbered positions mapped to lsb index 31-n
  localparam logic [31:0] ECREC_IMPL_MASK = 32'h73E7_5400;

  // debug control bits
  localparam int ECREC_DC_ENABLE = 0;
  localparam int ECREC_DC_IPROT_EN = 1;
  localparam int ECREC_DC_DPROT_EN = 2;

endpackage

// File: rtl/ecrec_top.sv
// Purpose: records the cause of each exception or event seen by the core
// Assumes: event inputs are synchronous single-cycle or level requests
// Notes: a read of the cause word clears it; set wins over that clear
//
// The plain strobed port and the placing of the registers were chosen for this implementation.

`timescale 1ns/10ps

// Behaviour
// - the reset-cause flag at bit 1 is set whenever the system reset pin is asserted.
// - the checkstop flag at bit 2 is set when the core enters checkstop.
// - the machine check flag at bit 3 is set on machine checks not caused by storage errors.
// - the outside interrupt flag at bit 6 is set while the external interrupt is asserted.
// - the alignment fault flag at bit 7 is set on an alignment exception.
// - the program fault flag at bit 8 is set on a program exception.
// - the float unavailable flag sits at bit 9 and is set by its own exception input.
// - the decrementer flag at bit 10 is set on a decrementer exception.
// - the system call flag at bit 13 is set on a system call exception.
// - the single step or branch flag at bit 14 is set in single-step or branch trace mode.
// - the float assist flag at bit 15 is set on a floating point assist exception.
// - the emulation trap flag at bit 17 is set on a software emulation exception.
// - an instruction protection error sets bit 19 and asks for debug entry only if enabled.
// - a data protection error sets bit 21 and asks for debug entry only if enabled.
module ecrec_top
  import ecrec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ECREC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic sys_reset_pin,
  input wire logic checkstop_entry,
  input wire logic machine_check,
  input wire logic mcheck_storage_err,
  input wire logic outside_interrupt,
  input wire logic alignment_fault,
  input wire logic program_fault,
  input wire logic float_unavailable,
  input wire logic decrementer_exc,
  input wire logic system_call,
  input wire logic single_step_mode,
  input wire logic branch_trace_mode,
  input wire logic float_assist,
  input wire logic emulation_trap,
  input wire logic instr_protection_error,
  input wire logic data_protection_error,
  output logic debug_entry_req,
  output logic irq
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync_n;

  // two flip-flops release the asynchronous reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // msb-numbered bit n becomes a one-hot word
  function automatic logic [31:0] ecrec_bit(input int n);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[31-n] = 1'b1;
    return w;
  endfunction

  // ----------------------------------------
  // event collection
  // ----------------------------------------
  wire logic mcheck_counted;
  wire logic trace_active;
  wire logic [31:0] event_word;

  assign mcheck_counted = machine_check & ~mcheck_storage_err;
  assign trace_active = single_step_mode | branch_trace_mode;

  // each event source lands on its own cause position, except the two trace modes, which share bit 14
  assign event_word =
    ({32{sys_reset_pin}} & ecrec_bit(ECREC_B_RESET))
    | ({32{checkstop_entry}} & ecrec_bit(ECREC_B_CHECKSTOP))
    | ({32{mcheck_counted}} & ecrec_bit(ECREC_B_MCHECK))
    | ({32{outside_interrupt}} & ecrec_bit(ECREC_B_OUTSIDE))
    | ({32{alignment_fault}} & ecrec_bit(ECREC_B_ALIGN))
    | ({32{program_fault}} & ecrec_bit(ECREC_B_PROGRAM))
    | ({32{float_unavailable}} & ecrec_bit(ECREC_B_FPUNAVAIL))
    | ({32{decrementer_exc}} & ecrec_bit(ECREC_B_DECR))
    | ({32{system_call}} & ecrec_bit(ECREC_B_SYSCALL))
    | ({32{trace_active}} & ecrec_bit(ECREC_B_TRACE))
    | ({32{float_assist}} & ecrec_bit(ECREC_B_FPASSIST))
    | ({32{emulation_trap}} & ecrec_bit(ECREC_B_EMUL))
    | ({32{instr_protection_error}} & ecrec_bit(ECREC_B_IPROT))
    | ({32{data_protection_error}} & ecrec_bit(ECREC_B_DPROT));

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic [31:0] exception_cause_flags;
  logic [31:0] irq_mask;
  logic [2:0] debug_ctl;
  wire logic sel_cause;
  wire logic sel_mask;
  wire logic sel_dbg;
  wire logic cause_read;
  wire logic [31:0] next_cause;
  wire logic [31:0] next_rdata;
  wire logic next_debug_req;
  wire logic next_irq;
  wire logic [31:0] next_mask;

  assign sel_cause = (reg_addr == ECREC_OFF_CAUSE);
  assign sel_mask = (reg_addr == ECREC_OFF_MASK);
  assign sel_dbg = (reg_addr == ECREC_OFF_DBGCTL);
  assign cause_read = reg_read & sel_cause;

  // flags are sticky; a read clears them but a same-cycle event survives
  assign next_cause = ((cause_read ? 32'h0000_0000 : exception_cause_flags)
    | event_word) & ECREC_IMPL_MASK;

  // read data mux, unmapped addresses read zero
  assign next_rdata = sel_cause ? exception_cause_flags :
    sel_mask ? irq_mask :
    sel_dbg ? {29'h0, debug_ctl} : 32'h0000_0000;

  // debug entry only when globally enabled and the matching enable is set
  assign next_debug_req = debug_ctl[ECREC_DC_ENABLE]
    & ((instr_protection_error & debug_ctl[ECREC_DC_IPROT_EN])
    | (data_protection_error & debug_ctl[ECREC_DC_DPROT_EN]));

  // mask as it stands after this edge, so irq never lags a mask write
  assign next_mask = (reg_write && sel_mask) ? (reg_wdata & ECREC_IMPL_MASK) : irq_mask;
  assign next_irq = |(next_cause & next_mask);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // cause flags
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      exception_cause_flags <= ECREC_CAUSE_RESET;
    else
      exception_cause_flags <= next_cause;
  end

  // software-written mask and debug control
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      irq_mask <= ECREC_MASK_RESET;
      debug_ctl <= ECREC_DBGCTL_RESET;
    end
    else if (reg_write)
    begin
      if (sel_mask)
        irq_mask <= reg_wdata & ECREC_IMPL_MASK;
      if (sel_dbg)
        debug_ctl <= reg_wdata[2:0];
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      reg_rdata <= 32'h0000_0000;
      debug_entry_req <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_read ? next_rdata : 32'h0000_0000;
      debug_entry_req <= next_debug_req;
      irq <= next_irq;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reset_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    sys_reset_pin |=> exception_cause_flags[31-ECREC_B_RESET];
  endproperty
  a_reset_flag: assert property (p_reset_flag)
    else $error("reset cause flag not set");

  property p_checkstop_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    checkstop_entry |=> exception_cause_flags[31-ECREC_B_CHECKSTOP];
  endproperty
  a_checkstop_flag: assert property (p_checkstop_flag)
    else $error("checkstop flag not set");

  property p_mcheck_storage;
    @(posedge clk) disable iff (!rst_sync_n)
    (machine_check && mcheck_storage_err && !exception_cause_flags[31-ECREC_B_MCHECK]
      && !(reg_write && sel_cause)) |=> !exception_cause_flags[31-ECREC_B_MCHECK];
  endproperty
  a_mcheck_storage: assert property (p_mcheck_storage)
    else $error("storage machine check set its flag");

  property p_mcheck_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    (machine_check && !mcheck_storage_err) |=> exception_cause_flags[31-ECREC_B_MCHECK];
  endproperty
  a_mcheck_flag: assert property (p_mcheck_flag)
    else $error("machine check flag not set");

  property p_outside_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    outside_interrupt |=> exception_cause_flags[31-ECREC_B_OUTSIDE];
  endproperty
  a_outside_flag: assert property (p_outside_flag)
    else $error("outside interrupt flag not set");

  property p_trace_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    (single_step_mode || branch_trace_mode) |=> exception_cause_flags[31-ECREC_B_TRACE];
  endproperty
  a_trace_flag: assert property (p_trace_flag)
    else $error("trace flag not set");

  property p_iprot_debug;
    @(posedge clk) disable iff (!rst_sync_n)
    (instr_protection_error && debug_ctl[ECREC_DC_ENABLE] && debug_ctl[ECREC_DC_IPROT_EN])
      |=> debug_entry_req && exception_cause_flags[31-ECREC_B_IPROT];
  endproperty
  a_iprot_debug: assert property (p_iprot_debug)
    else $error("instruction protection error not handled");

  property p_dprot_debug;
    @(posedge clk) disable iff (!rst_sync_n)
    (data_protection_error && debug_ctl[ECREC_DC_ENABLE] && debug_ctl[ECREC_DC_DPROT_EN])
      |=> debug_entry_req && exception_cause_flags[31-ECREC_B_DPROT];
  endproperty
  a_dprot_debug: assert property (p_dprot_debug)
    else $error("data protection error not handled");

  property p_no_debug_disabled;
    @(posedge clk) disable iff (!rst_sync_n)
    !debug_ctl[ECREC_DC_ENABLE] |=> !debug_entry_req;
  endproperty
  a_no_debug_disabled: assert property (p_no_debug_disabled)
    else $error("debug entry while debug disabled");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_sync_n)
    (exception_cause_flags & ~ECREC_IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved cause bit set");

  property p_sticky;
    @(posedge clk) disable iff (!rst_sync_n)
    (exception_cause_flags[31-ECREC_B_ALIGN] && !cause_read)
      |=> exception_cause_flags[31-ECREC_B_ALIGN];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("alignment flag lost without a read");

  property p_read_returns;
    @(posedge clk) disable iff (!rst_sync_n)
    cause_read |=> reg_rdata == $past(exception_cause_flags);
  endproperty
  a_read_returns: assert property (p_read_returns)
    else $error("cause read returned wrong data");

  property p_align_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    alignment_fault |=> exception_cause_flags[31-ECREC_B_ALIGN];
  endproperty
  a_align_flag: assert property (p_align_flag)
    else $error("alignment flag not set");

  property p_fpunavail_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    float_unavailable |=> exception_cause_flags[31-ECREC_B_FPUNAVAIL];
  endproperty
  a_fpunavail_flag: assert property (p_fpunavail_flag)
    else $error("float unavailable flag not set");

  property p_irq_level;
    @(posedge clk) disable iff (!rst_sync_n)
    irq == (|(exception_cause_flags & irq_mask));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq does not follow unmasked flags");

  property p_debug_cause;
    @(posedge clk) disable iff (!rst_sync_n)
    debug_entry_req |-> $past(instr_protection_error || data_protection_error);
  endproperty
  a_debug_cause: assert property (p_debug_cause)
    else $error("debug entry without a protection error");

  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_sync_n)
    !reg_read |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

endmodule

// File: dv/ecrec_core_model.sv
// Purpose: model of the core exception logic feeding the cause recorder
// Assumes: the bench raises fire bits right after a clock edge
// Notes: one fire bit per event line, held as long as the bench holds it

`timescale 1ns/10ps

module ecrec_core_model
(
  input wire logic [14:0] fire,
  input wire logic storage_err,
  output logic sys_reset_pin,
  output logic checkstop_entry,
  output logic machine_check,
  output logic mcheck_storage_err,
  output logic outside_interrupt,
  output logic alignment_fault,
  output logic program_fault,
  output logic float_unavailable,
  output logic decrementer_exc,
  output logic system_call,
  output logic single_step_mode,
  output logic branch_trace_mode,
  output logic float_assist,
  output logic emulation_trap,
  output logic instr_protection_error,
  output logic data_protection_error
);
  // event lines, each raised by its own fire bit
  assign sys_reset_pin = fire[0];
  assign checkstop_entry = fire[1];
  assign machine_check = fire[2];
  assign mcheck_storage_err = storage_err;
  assign outside_interrupt = fire[3];
  assign alignment_fault = fire[4];
  assign program_fault = fire[5];
  assign float_unavailable = fire[6];
  assign decrementer_exc = fire[7];
  assign system_call = fire[8];
  assign single_step_mode = fire[9];
  assign branch_trace_mode = fire[10];
  assign float_assist = fire[11];
  assign emulation_trap = fire[12];
  assign instr_protection_error = fire[13];
  assign data_protection_error = fire[14];
endmodule

// File: dv/tb_exception_cause_recorder.sv
// Purpose: self-checking bench for the exception cause recorder
// Assumes: register port answers one cycle after the read strobe
// Notes: expected words are built from the flag position table here

`timescale 1ns/10ps

module tb_exception_cause_recorder
  import ecrec_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic merr = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [14:0] fire = 15'h0;
  logic [31:0] reg_rdata, impl;
  logic debug_entry_req, irq, sys_reset_pin, checkstop_entry, machine_check;
  logic mcheck_storage_err, outside_interrupt, alignment_fault, program_fault;
  logic float_unavailable, decrementer_exc, system_call, single_step_mode;
  logic branch_trace_mode, float_assist, emulation_trap;
  logic instr_protection_error, data_protection_error;
  int pos[15] = '{1, 2, 3, 6, 7, 8, 9, 10, 13, 14, 14, 15, 17, 19, 21};
  int error_cnt = 0;
  int checks = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  ecrec_core_model core (.fire, .storage_err(merr), .sys_reset_pin, .checkstop_entry,
    .machine_check, .mcheck_storage_err, .outside_interrupt, .alignment_fault,
    .program_fault, .float_unavailable, .decrementer_exc, .system_call, .single_step_mode,
    .branch_trace_mode, .float_assist, .emulation_trap, .instr_protection_error,
    .data_protection_error);

  ecrec_top dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .sys_reset_pin, .checkstop_entry, .machine_check, .mcheck_storage_err,
    .outside_interrupt, .alignment_fault, .program_fault, .float_unavailable,
    .decrementer_exc, .system_call, .single_step_mode, .branch_trace_mode, .float_assist,
    .emulation_trap, .instr_protection_error, .data_protection_error, .debug_entry_req,
    .irq);

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // one-cycle event; returns just after the edge that samples it
  task ev(input int i);
    @(posedge clk);
    fire <= 15'h1 << i;
    @(posedge clk);
    fire <= 15'h0;
    #1;
  endtask

  task final_report;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    impl = 32'h0;
    foreach (pos[i])
      impl |= 32'h1 << (31 - pos[i]);
    rdc(ECREC_OFF_CAUSE, 32'h0);
    rdc(ECREC_OFF_MASK, 32'h0);
    rdc(ECREC_OFF_DBGCTL, 32'h0);
    rdc(4'hC, 32'h0);
    // each event alone sets only its own flag, then the read clears it
    foreach (pos[i])
    begin
      ev(i);
      rdc(ECREC_OFF_CAUSE, 32'h1 << (31 - pos[i]));
      rdc(ECREC_OFF_CAUSE, 32'h0);
    end
    // storage-error machine check leaves no flag
    @(posedge clk);
    merr <= 1'b1;
    ev(2);
    merr <= 1'b0;
    rdc(ECREC_OFF_CAUSE, 32'h0);
    // all events at once for one cycle, flags held across idle cycles
    @(posedge clk);
    fire <= 15'h7FFF;
    @(posedge clk);
    fire <= 15'h0;
    repeat (5) @(posedge clk);
    rdc(ECREC_OFF_CAUSE, impl);
    wr(ECREC_OFF_CAUSE, 32'hFFFF_FFFF);
    rdc(ECREC_OFF_CAUSE, 32'h0);
    wr(ECREC_OFF_MASK, 32'hFFFF_FFFF);
    rdc(ECREC_OFF_MASK, impl);
    // interrupt raised, cleared by the read, then masked out
    ev(4);
    chk({31'h0, irq}, 32'h1);
    rdc(ECREC_OFF_CAUSE, 32'h1 << 24);
    chk({31'h0, irq}, 32'h0);
    wr(ECREC_OFF_MASK, 32'h1 << 24);
    ev(5);
    chk({31'h0, irq}, 32'h0);
    rdc(ECREC_OFF_CAUSE, 32'h1 << 23);
    // debug entry only with global and per-error enables
    wr(ECREC_OFF_DBGCTL, 32'h6);
    ev(13);
    chk({31'h0, debug_entry_req}, 32'h0);
    wr(ECREC_OFF_DBGCTL, 32'h3);
    ev(13);
    chk({31'h0, debug_entry_req}, 32'h1);
    ev(14);
    chk({31'h0, debug_entry_req}, 32'h0);
    wr(ECREC_OFF_DBGCTL, 32'h5);
    rdc(ECREC_OFF_DBGCTL, 32'h5);
    ev(14);
    chk({31'h0, debug_entry_req}, 32'h1);
    rdc(ECREC_OFF_CAUSE, 32'h0000_1400);
    // a mid-run reset clears a pending flag, its interrupt and the mask
    ev(4);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rdc(ECREC_OFF_CAUSE, 32'h0);
    rdc(ECREC_OFF_MASK, 32'h0);
    final_report;
  end

  // watchdog against a hung run
  initial
  begin
    #(40 * 2000);
    error_cnt++;
    final_report;
  end
endmodule
